// [design/iac_pkg.sv]
// Operation
// - slave may hold SCL low, stretching low
// - 10-bit first byte starts with 11110 prefix
// - first 10-bit byte matched, write direction, ack
// - second byte full match, single ack
// - stays selected until stop, other address or nack to slave transmit
// - interrupt after first 10-bit address byte
// - repeated start, read prefix, reselected transmitter
// - unaddressed slaves ignore 10-bit read prefix
// - general call matched when enabled, slave receive
// - general call not acknowledged when disabled
// - comes up disabled, no reset request
// - one interrupt from flag and enable
// - common flag cleared only by writing one
// - transfer complete at ninth clock falling edge
// - arbitration lost on transmit bit mismatch
// - arbitration lost on receive acknowledge mismatch
// - lost on busy start, slave restart, stray stop
// - arbitration flag held until written one
// - losing master releases SDA, no stop
// - extension select picks 7 or 10 bits
package iac_pkg;
    localparam int         IAC_DIV_W      = 8;
    localparam logic [7:0] IAC_GEN_CALL   = 8'h00;
    localparam logic [7:0] IAC_BYTE_ZERO  = 8'h00;
    localparam logic [4:0] IAC_TEN_PREFIX = 5'h1e;
    localparam logic [3:0] IAC_BIT_ZERO   = 4'h0;
    localparam logic [3:0] IAC_BIT_PRE    = 4'hf;
    localparam logic [3:0] IAC_BIT_ONE    = 4'h1;
    localparam logic [3:0] IAC_BIT_LAST   = 4'h7;
    localparam logic [3:0] IAC_BIT_ACK    = 4'h8;

    typedef enum logic [3:0]
    {
        IAC_M_IDLE   = 4'h0,
        IAC_M_START  = 4'h1,
        IAC_M_HOLD   = 4'h3,
        IAC_M_LOW    = 4'h2,
        IAC_M_HIGH   = 4'h6,
        IAC_M_STOP_A = 4'h7,
        IAC_M_STOP_B = 4'h5,
        IAC_M_RS_A   = 4'h4,
        IAC_M_RS_B   = 4'hc
    } iac_mstate_type;

    typedef enum logic [1:0]
    {
        IAC_PH_IDLE  = 2'h0,
        IAC_PH_ADDR1 = 2'h1,
        IAC_PH_ADDR2 = 2'h3,
        IAC_PH_DATA  = 2'h2
    } iac_phase_type;
endpackage : iac_pkg

// [design/iac_sync.sv]
`timescale 1ns/1ns
module iac_sync
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // asynchronous line
    input  wire logic line_in,
    // synchronised level and edges
    output logic      level_q,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic prev_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q  <= 1'b1;
            level_q <= 1'b1;
            prev_q  <= 1'b1;
        end
        else
        begin
            meta_q  <= line_in;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

    assign rise = level_q & ~prev_q;
    assign fall = ~level_q & prev_q;
endmodule : iac_sync

// [design/iac_ctrl.sv]
`timescale 1ns/1ns
module iac_ctrl
#(
    parameter int DIV_W = iac_pkg::IAC_DIV_W
)
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // main control
    input  wire logic             module_enable,
    input  wire logic             common_interrupt_enable,
    input  wire logic             master_select,
    input  wire logic             repeat_start_req,
    input  wire logic             ack_disable,
    input  wire logic [DIV_W-1:0] baud_divider,
    // address control
    input  wire logic             general_call_enable,
    input  wire logic             address_extension_select,
    input  wire logic [2:0]       upper_address,
    input  wire logic [6:0]       own_address,
    // data register
    input  wire logic             data_wr,
    input  wire logic [7:0]       data_wr_value,
    input  wire logic             data_rd,
    output logic      [7:0]       bus_data_q,
    // write-one clears
    input  wire logic             clear_interrupt_flag,
    input  wire logic             clear_arbitration_lost,
    // status
    output logic                  common_interrupt_flag_q,
    output logic                  transfer_complete_flag_q,
    output logic                  addressed_as_slave_flag_q,
    output logic                  arbitration_lost_flag_q,
    output logic                  slave_direction_flag_q,
    output logic                  bus_busy_q,
    output logic                  irq_q,
    // bus lines
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  scl_out_q,
    output logic                  scl_oe_q,
    output logic                  sda_out_q,
    output logic                  sda_oe_q
);
    import iac_pkg::*;

    logic           scl_lvl;
    logic           scl_rise;
    logic           scl_fall;
    logic           sda_lvl;
    logic           sda_rise;
    logic           sda_fall;
    logic [3:0]     bit_cnt_q;
    logic [3:0]     bit_cnt_d;
    logic [7:0]     rx_q;
    logic [7:0]     tx_q;
    logic           rx_nack_q;
    iac_phase_type  phase_q;
    iac_phase_type  phase_d;
    logic           slv_q;
    logic           slv_tx_q;
    logic           sel10_q;
    logic           first10_q;
    logic           hit_q;
    logic           ack_q;
    logic           stretch_q;
    logic           ms_q;
    logic           after_start_q;
    logic           m_addr_q;
    logic           m_rx_q;
    iac_mstate_type m_state_q;
    iac_mstate_type m_state_d;
    logic [DIV_W-1:0] m_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // line synchronisers
    iac_sync u_scl_sync
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .line_in (scl_in),
        .level_q (scl_lvl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    iac_sync u_sda_sync
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .line_in (sda_in),
        .level_q (sda_lvl),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // framing and address decode
    wire en          = module_enable;
    wire start_det   = sda_fall & scl_lvl;
    wire stop_det    = sda_rise & scl_lvl;
    wire framing     = phase_q != IAC_PH_IDLE;
    wire in_bits     = bit_cnt_q < IAC_BIT_ACK;
    wire at_ack      = bit_cnt_q == IAC_BIT_ACK;
    wire eighth_fall = scl_fall & framing & (bit_cnt_q == IAC_BIT_LAST);
    wire byte_fall   = scl_fall & framing & at_ack;
    wire m_idle      = m_state_q == IAC_M_IDLE;
    wire [7:0] own_low8 = {upper_address[0], own_address};
    wire ten_hdr     = (rx_q[7:3] == IAC_TEN_PREFIX) & (rx_q[2:1] == upper_address[2:1]);
    wire gc_hit      = general_call_enable & (rx_q == IAC_GEN_CALL);
    wire seven_hit   = ~address_extension_select & (rx_q[7:1] == own_address);
    wire ten_first   = address_extension_select & ten_hdr & ~rx_q[0];
    wire ten_read    = address_extension_select & ten_hdr & rx_q[0] & sel10_q;
    wire ten_second  = first10_q & (rx_q == own_low8);
    wire full1       = m_idle & (gc_hit | seven_hit | ten_read);
    wire tx_sel1     = ten_read | (seven_hit & rx_q[0]);
    wire ack1        = full1 | (m_idle & ten_first);
    wire ack2        = m_idle & ten_second;
    wire ack_data    = slv_q & ~slv_tx_q;
    wire ack_next    = (phase_q == IAC_PH_ADDR1) ? ack1 :
                       (phase_q == IAC_PH_ADDR2) ? ack2 : ack_data;

    // the start's own scl fall wraps the count to zero
    assign bit_cnt_d = ~en ? IAC_BIT_ZERO :
                       start_det ? IAC_BIT_PRE :
                       (scl_fall & framing) ? (at_ack ? IAC_BIT_ZERO : bit_cnt_q + IAC_BIT_ONE) :
                       bit_cnt_q;
    assign phase_d   = (~en | stop_det) ? IAC_PH_IDLE :
                       start_det ? IAC_PH_ADDR1 :
                       ~byte_fall ? phase_q :
                       (phase_q == IAC_PH_ADDR1 & first10_q) ? IAC_PH_ADDR2 :
                       (phase_q == IAC_PH_IDLE) ? IAC_PH_IDLE : IAC_PH_DATA;

    ////////////////////////////////////////////////////////////////////////
    // bit engine
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_q <= IAC_BIT_ZERO;
            phase_q   <= IAC_PH_IDLE;
            rx_q      <= IAC_BYTE_ZERO;
            rx_nack_q <= 1'b1;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_d;
            phase_q   <= phase_d;
            if (scl_rise & framing & in_bits)
                rx_q <= {rx_q[6:0], sda_lvl};
            if (scl_rise & framing & at_ack)
                rx_nack_q <= sda_lvl;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            tx_q <= IAC_BYTE_ZERO;
        else if (data_wr)
            tx_q <= data_wr_value;
        else if (scl_fall & framing & (bit_cnt_q < IAC_BIT_LAST))
            tx_q <= {tx_q[6:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////
    // slave selection
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            slv_q     <= 1'b0;
            slv_tx_q  <= 1'b0;
            sel10_q   <= 1'b0;
            first10_q <= 1'b0;
            hit_q     <= 1'b0;
            ack_q     <= 1'b0;
        end
        else if (~en | stop_det)
        begin
            slv_q     <= 1'b0;
            slv_tx_q  <= 1'b0;
            sel10_q   <= 1'b0;
            first10_q <= 1'b0;
            hit_q     <= 1'b0;
            ack_q     <= 1'b0;
        end
        else if (eighth_fall)
        begin
            ack_q <= ack_next;
            if (phase_q == IAC_PH_ADDR1)
            begin
                slv_q     <= full1;
                slv_tx_q  <= full1 & tx_sel1;
                sel10_q   <= m_idle & ten_read;
                first10_q <= m_idle & ten_first;
                hit_q     <= full1;
            end
            else if (phase_q == IAC_PH_ADDR2)
            begin
                slv_q     <= ack2;
                slv_tx_q  <= 1'b0;
                sel10_q   <= ack2;
                first10_q <= 1'b0;
                hit_q     <= ack2;
            end
        end
        else if (byte_fall)
        begin
            ack_q <= 1'b0;
            hit_q <= 1'b0;
            if (slv_tx_q & rx_nack_q & phase_q == IAC_PH_DATA)
                slv_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags and interrupt
    wire involved  = ~m_idle | slv_q | ack_q;
    wire svc       = data_wr | data_rd;
    wire tcf_set   = byte_fall & involved;
    wire aas_set   = byte_fall & hit_q;
    wire st_set    = byte_fall & m_idle & (ack_q | (slv_q & slv_tx_q & ~rx_nack_q));
    wire ms_rise   = master_select & ~ms_q;
    wire m_run     = (m_state_q == IAC_M_LOW) | (m_state_q == IAC_M_HIGH);
    wire m_txing   = m_addr_q | ~m_rx_q;
    wire m_low_bit = in_bits ? (m_txing & ~tx_q[7]) : (~m_txing & ~ack_disable);
    wire arb_bit   = scl_rise & m_run & ~m_low_bit & ~sda_lvl &
                     ((in_bits & m_txing) | (at_ack & ~m_txing));
    wire arb_start = ms_rise & bus_busy_q;
    wire arb_rs    = repeat_start_req & m_idle;
    wire arb_stop  = stop_det & ~m_idle;
    wire arb_evt   = en & (arb_bit | arb_start | arb_rs | arb_stop);
    wire tcf_d     = tcf_set | (transfer_complete_flag_q & ~svc);
    wire aas_d     = aas_set | (addressed_as_slave_flag_q & ~(data_wr | start_det));
    wire arb_d     = arb_evt | (arbitration_lost_flag_q & ~clear_arbitration_lost);
    wire if_d      = tcf_set | aas_set | arb_evt |
                     (common_interrupt_flag_q & ~clear_interrupt_flag);
    wire st_d      = en & ~stop_det & (st_set | (stretch_q & ~svc));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            transfer_complete_flag_q  <= 1'b0;
            addressed_as_slave_flag_q <= 1'b0;
            arbitration_lost_flag_q   <= 1'b0;
            common_interrupt_flag_q   <= 1'b0;
            irq_q                     <= 1'b0;
            stretch_q                 <= 1'b0;
        end
        else
        begin
            transfer_complete_flag_q  <= tcf_d;
            addressed_as_slave_flag_q <= aas_d;
            arbitration_lost_flag_q   <= arb_d;
            common_interrupt_flag_q   <= if_d;
            irq_q                     <= if_d & common_interrupt_enable;
            stretch_q                 <= st_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            slave_direction_flag_q <= 1'b0;
            bus_data_q             <= IAC_BYTE_ZERO;
            bus_busy_q             <= 1'b0;
        end
        else
        begin
            if (byte_fall & hit_q)
                slave_direction_flag_q <= slv_tx_q;
            if (byte_fall)
                bus_data_q <= rx_q;
            if (~en | stop_det)
                bus_busy_q <= 1'b0;
            else if (start_det)
                bus_busy_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master sequencer
    wire m_tick  = m_cnt_q >= baud_divider;
    wire m_wait  = (m_state_q == IAC_M_HIGH) | (m_state_q == IAC_M_STOP_B) | (m_state_q == IAC_M_RS_B);
    wire m_go    = data_wr | (data_rd & m_rx_q & ~m_addr_q);
    wire h_tick  = m_tick & scl_lvl;

    always_comb
    begin
        m_state_d = m_state_q;
        case (m_state_q)
            IAC_M_IDLE:
                if (ms_rise & ~bus_busy_q)
                    m_state_d = IAC_M_START;
            IAC_M_START:
                if (m_tick)
                    m_state_d = IAC_M_HOLD;
            IAC_M_HOLD:
                if (~master_select)
                    m_state_d = IAC_M_STOP_A;
                else if (repeat_start_req)
                    m_state_d = IAC_M_RS_A;
                else if (m_go)
                    m_state_d = IAC_M_LOW;
            IAC_M_LOW:
                if (m_tick)
                    m_state_d = IAC_M_HIGH;
            IAC_M_HIGH:
                if (h_tick)
                    m_state_d = at_ack ? IAC_M_HOLD : IAC_M_LOW;
            IAC_M_STOP_A:
                if (m_tick)
                    m_state_d = IAC_M_STOP_B;
            IAC_M_STOP_B:
                if (h_tick)
                    m_state_d = IAC_M_IDLE;
            IAC_M_RS_A:
                if (m_tick)
                    m_state_d = IAC_M_RS_B;
            IAC_M_RS_B:
                if (h_tick)
                    m_state_d = IAC_M_START;
            default:
                m_state_d = IAC_M_IDLE;
        endcase
        if (~en | arb_evt)
            m_state_d = IAC_M_IDLE;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            m_state_q <= IAC_M_IDLE;
            m_cnt_q   <= '0;
            ms_q      <= 1'b0;
        end
        else
        begin
            m_state_q <= m_state_d;
            ms_q      <= master_select;
            // high phase counts only once the line is seen high
            if ((m_state_d != m_state_q) | (m_wait & ~scl_lvl))
                m_cnt_q <= '0;
            else if (~m_tick)
                m_cnt_q <= m_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            after_start_q <= 1'b0;
            m_addr_q      <= 1'b0;
            m_rx_q        <= 1'b0;
        end
        else if (m_state_q == IAC_M_START)
        begin
            after_start_q <= 1'b1;
            m_addr_q      <= 1'b1;
        end
        else
        begin
            if (m_state_q == IAC_M_LOW)
                after_start_q <= 1'b0;
            if (m_state_q == IAC_M_HIGH & m_state_d == IAC_M_HOLD)
                m_addr_q <= 1'b0;
            if (m_state_q == IAC_M_HOLD & m_addr_q & data_wr)
                m_rx_q <= data_wr_value[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line drivers
    wire m_scl_low = (m_state_q == IAC_M_HOLD) | (m_state_q == IAC_M_LOW) |
                     (m_state_q == IAC_M_STOP_A) | (m_state_q == IAC_M_RS_A);
    wire m_sda_low = (m_state_q == IAC_M_START) | (m_state_q == IAC_M_STOP_A) |
                     (m_state_q == IAC_M_STOP_B) |
                     ((m_state_q == IAC_M_HOLD) & (after_start_q | m_low_bit)) |
                     (m_run & m_low_bit);
    wire s_low     = in_bits ? (slv_q & slv_tx_q & (phase_q == IAC_PH_DATA) & ~tx_q[7]) : ack_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_oe_q  <= 1'b0;
            sda_oe_q  <= 1'b0;
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
        end
        else
        begin
            scl_oe_q  <= en & (m_scl_low | stretch_q);
            sda_oe_q  <= en & (m_sda_low | s_low);
            scl_out_q <= 1'b0;
            sda_out_q <= 1'b0;
        end
    end
endmodule : iac_ctrl

// [verif/iac_ctrl_assertions.sv]
`timescale 1ns/1ns
module iac_ctrl_assertions
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // controls
    input wire logic module_enable,
    input wire logic common_interrupt_enable,
    input wire logic master_select,
    input wire logic repeat_start_req,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic clear_interrupt_flag,
    input wire logic clear_arbitration_lost,
    input wire logic scl_in,
    // status and lines
    input wire logic common_interrupt_flag_q,
    input wire logic transfer_complete_flag_q,
    input wire logic addressed_as_slave_flag_q,
    input wire logic arbitration_lost_flag_q,
    input wire logic slave_direction_flag_q,
    input wire logic irq_q,
    input wire logic scl_oe_q,
    input wire logic sda_oe_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////
    irq_gate_a: assert property (irq_q == (common_interrupt_flag_q && $past(common_interrupt_enable)))
        else $error("irq not flag and enable");
    flag_cause_a: assert property ($rose(common_interrupt_flag_q) |->
        transfer_complete_flag_q || addressed_as_slave_flag_q || arbitration_lost_flag_q)
        else $error("flag rose without event");
    flag_hold_a: assert property (common_interrupt_flag_q && !clear_interrupt_flag |=> common_interrupt_flag_q)
        else $error("flag dropped without clear");
    arb_hold_a: assert property (arbitration_lost_flag_q && !clear_arbitration_lost |=> arbitration_lost_flag_q)
        else $error("arb flag dropped without clear");
    arb_restart_a: assert property (repeat_start_req && module_enable && !master_select
        |-> ##[1:3] arbitration_lost_flag_q)
        else $error("slave restart not lost");
    off_release_a: assert property (!module_enable [*2] |-> !scl_oe_q && !sda_oe_q)
        else $error("disabled block pulls a line");
    tcf_fall_a: assert property ($rose(transfer_complete_flag_q) |-> !scl_in)
        else $error("tcf set while scl high");
    stretch_hold_a: assert property (scl_oe_q && !sda_oe_q && !master_select && module_enable
        && !data_rd && !data_wr && !$past(data_rd) && !$past(data_wr) |=> scl_oe_q)
        else $error("stretch released early");
    aas_clear_a: assert property (data_wr |=> !addressed_as_slave_flag_q)
        else $error("aas kept after data write");
    srw_sel_a: assert property ($rose(slave_direction_flag_q) |-> addressed_as_slave_flag_q)
        else $error("srw set while unselected");
    aas_c: cover property ($rose(addressed_as_slave_flag_q));
    arb_c: cover property ($rose(arbitration_lost_flag_q));
    srw_c: cover property ($rose(slave_direction_flag_q));
endmodule : iac_ctrl_assertions

bind iac_ctrl iac_ctrl_assertions u_chk (.ref_clk, .rst, .module_enable, .common_interrupt_enable,
    .master_select, .repeat_start_req, .data_wr, .data_rd, .clear_interrupt_flag, .clear_arbitration_lost,
    .scl_in, .common_interrupt_flag_q, .transfer_complete_flag_q, .addressed_as_slave_flag_q,
    .arbitration_lost_flag_q, .slave_direction_flag_q, .irq_q, .scl_oe_q, .sda_oe_q);

// [verif/iac_bus_master_model.sv]
`timescale 1ns/1ns
module iac_bus_master_model
(
    // bus lines
    input  wire logic scl,
    input  wire logic sda,
    // open-drain pulls
    output logic      scl_pull,
    output logic      sda_pull
);
    localparam int HALF = 80;
    int n_hang = 0;
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    ////////////////////////////////
    // release scl, wait out a stretch of up to 40000 ns, else count a hang
    task automatic rise_scl();
        int i;
        scl_pull = 1'b0;
        for (i = 0; i < 4000 && scl !== 1'b1; i++) #10;
        if (i == 4000) n_hang++;
        #HALF;
    endtask : rise_scl
    task automatic start();
        sda_pull = 1'b1;
        #HALF;
        scl_pull = 1'b1;
        #HALF;
    endtask : start
    task automatic restart();
        sda_pull = 1'b0;
        #(HALF/2);
        rise_scl();
        start();
    endtask : restart
    task automatic stop();
        sda_pull = 1'b1;
        #(HALF/2);
        rise_scl();
        sda_pull = 1'b0;
        #HALF;
    endtask : stop
    // msb first, ack slot always released
    task automatic send_byte(input logic [7:0] tx, output logic ack, output logic [7:0] rx);
        for (int b = 8; b >= 0; b--)
        begin
            #(HALF/2);
            sda_pull = (b > 0) ? ~tx[(b+7)%8] : 1'b0;
            #(HALF/2);
            rise_scl();
            if (b > 0) rx[(b+7)%8] = sda;
            ack = ~sda;
            scl_pull = 1'b1;
        end
        #HALF;
    endtask : send_byte
endmodule : iac_bus_master_model

// [verif/testbench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    import iac_pkg::*;
    localparam logic [4:0] P_RD = 5'h10, P_WR = 5'h08, P_CIF = 5'h04, P_CARB = 5'h02, P_RS = 5'h01;
    logic       ref_clk = 1'b0, rst = 1'b1;
    logic       module_enable = 1'b0, common_interrupt_enable = 1'b0, general_call_enable = 1'b0;
    logic       address_extension_select = 1'b0, data_rd = 1'b0, data_wr = 1'b0, repeat_start_req = 1'b0;
    logic       clear_interrupt_flag = 1'b0, clear_arbitration_lost = 1'b0, master_select = 1'b0;
    logic [2:0] upper_address = 3'h0;
    logic [6:0] own_address   = 7'h00;
    logic [7:0] bus_data_q, rx;
    logic       common_interrupt_flag_q, transfer_complete_flag_q, addressed_as_slave_flag_q;
    logic       arbitration_lost_flag_q, slave_direction_flag_q, irq_q, scl_oe_q, sda_oe_q, bus_busy_q;
    logic       m_scl, m_sda;
    wire        scl_w = ~(m_scl | scl_oe_q);
    wire        sda_w = ~(m_sda | sda_oe_q);
    int         n_fail = 0, check_count = 0;
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////
    iac_ctrl DUT (.ref_clk, .rst, .module_enable, .common_interrupt_enable, .master_select,
        .repeat_start_req, .ack_disable(1'b0), .baud_divider(8'h04), .general_call_enable,
        .address_extension_select, .upper_address, .own_address, .data_wr, .data_wr_value(8'h3c),
        .data_rd, .bus_data_q, .clear_interrupt_flag, .clear_arbitration_lost, .common_interrupt_flag_q,
        .transfer_complete_flag_q, .addressed_as_slave_flag_q, .arbitration_lost_flag_q,
        .slave_direction_flag_q, .bus_busy_q, .irq_q, .scl_in(scl_w), .sda_in(sda_w),
        .scl_out_q(), .scl_oe_q, .sda_out_q(), .sda_oe_q);
    iac_bus_master_model m (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));
    ////////////////////////////////
    task automatic pulse(input logic [4:0] k);
        @(negedge ref_clk);
        {data_rd, data_wr, clear_interrupt_flag, clear_arbitration_lost, repeat_start_req} = k;
        @(negedge ref_clk);
        {data_rd, data_wr, clear_interrupt_flag, clear_arbitration_lost, repeat_start_req} = 5'h00;
        repeat (3) @(negedge ref_clk);
    endtask : pulse
    task automatic xfer(input logic [7:0] tx, input logic exp_ack);
        logic ack;
        m.send_byte(tx, ack, rx);
        `CHK("ack", exp_ack, ack)
    endtask : xfer
    // tcf, aas, srw, irq
    task automatic flags(input string nm, input logic [3:0] e);
        `CHK(nm, e, {transfer_complete_flag_q, addressed_as_slave_flag_q, slave_direction_flag_q, irq_q})
    endtask : flags
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    ////////////////////////////////
    initial
    begin
        #900000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK("lines", 3'h0, {scl_oe_q, sda_oe_q, common_interrupt_flag_q})
        own_address = 7'h2a;
        upper_address = 3'h5;
        m.start();
        xfer(8'h54, 1'b0);
        m.stop();
        @(negedge ref_clk);
        module_enable = 1'b1;
        common_interrupt_enable = 1'b1;
        done("reset");
        m.start();
        xfer(8'h54, 1'b1);
        flags("own", 4'hd);
        `CHK("data", 8'h54, bus_data_q)
        pulse(P_WR);
        `CHK("aas", 1'b0, addressed_as_slave_flag_q)
        `CHK("flag", 1'b1, common_interrupt_flag_q)
        pulse(P_CIF);
        `CHK("flag", 1'b0, common_interrupt_flag_q)
        xfer(8'ha5, 1'b1);
        flags("byte", 4'h9);
        `CHK("data", 8'ha5, bus_data_q)
        pulse(P_RD);
        pulse(P_CIF);
        m.stop();
        done("own7");
        m.start();
        xfer(8'h00, 1'b0);
        `CHK("flag", 1'b0, common_interrupt_flag_q)
        m.stop();
        @(negedge ref_clk);
        general_call_enable = 1'b1;
        m.start();
        xfer(8'h00, 1'b1);
        flags("gcall", 4'hd);
        `CHK("data", 8'h00, bus_data_q)
        pulse(P_RD);
        pulse(P_CIF);
        m.stop();
        done("gcall");
        @(negedge ref_clk);
        address_extension_select = 1'b1;
        m.start();
        xfer(8'hf4, 1'b1);
        flags("ten1", 4'h9);
        pulse(P_RD);
        pulse(P_CIF);
        xfer(8'haa, 1'b1);
        flags("ten2", 4'hd);
        pulse(P_RD);
        pulse(P_CIF);
        m.restart();
        xfer(8'hf5, 1'b1);
        flags("ten3", 4'hf);
        pulse(P_WR);
        xfer(8'hff, 1'b0);
        `CHK("txbyte", 8'h3c, rx)
        pulse(P_CIF);
        m.stop();
        m.start();
        xfer(8'hf5, 1'b0);
        m.stop();
        done("ten");
        @(negedge ref_clk);
        common_interrupt_enable = 1'b0;
        pulse(P_RS);
        `CHK("arb", 3'h6, {arbitration_lost_flag_q, common_interrupt_flag_q, irq_q})
        repeat (20) @(negedge ref_clk);
        `CHK("arb", 1'b1, arbitration_lost_flag_q)
        pulse(P_CARB);
        `CHK("arb", 1'b0, arbitration_lost_flag_q)
        `CHK("hang", 0, m.n_hang)
        done("arb");
        master_select = 1'b1;
        repeat (20) @(negedge ref_clk);
        pulse(P_WR);
        repeat (200) @(negedge ref_clk);
        `CHK("mtx", 9'h13c, {transfer_complete_flag_q, bus_data_q})
        master_select = 1'b0;
        repeat (50) @(negedge ref_clk);
        `CHK("mstop", 2'h0, {bus_busy_q, arbitration_lost_flag_q})
        m.start();
        master_select = 1'b1;
        repeat (5) @(negedge ref_clk);
        `CHK("busy", 2'h3, {bus_busy_q, arbitration_lost_flag_q})
        master_select = 1'b0;
        m.stop();
        done("master");
        end_sim();
    end
endmodule : testbench
